// ---- logic/ggd_display_top.sv ----
// Gauge display driver, filter register and soft reset.
// Assumes a host register port and gauge core on one clock.
`timescale 1ns/10ps
`include "ggd_params.svh"
module ggd_display_top
  import ggd_pkg::*;
#(
  parameter int MUX_CYCLES = `GGD_MUX_PERIOD_NS / `GGD_CLK_NS,
  parameter int BANK_CYCLES = `GGD_BANK_ON_NS / `GGD_CLK_NS,
  parameter int BLINK_CYCLES = `GGD_BLINK_PERIOD_NS / `GGD_CLK_NS,
  parameter logic [7:0] FILTER_RESET = `GGD_FILTER_RESET
)
(
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire ggd_reg_req_t reg_req_in,
  output logic [7:0] reg_rdata_out,
  output logic reg_rvalid_out,
  input wire logic [7:0] programmed_full_capacity_in,
  input wire logic program_input_six_in,
  input wire logic absolute_mode_in,
  input wire logic [3:0] temperature_gauge_reg_in,
  input wire logic gauge_update_in,
  input wire ggd_state_t gauge_state_in,
  input wire logic discharge_active_in,
  input wire logic charge_active_in,
  input wire ggd_display_enable_input_t display_enable_input_in,
  input wire logic first_empty_warning_in,
  input wire logic final_empty_warning_in,
  output ggd_state_t gauge_state_out,
  output logic [7:0] magnitude_filter_limits_out,
  output logic soft_reset_out,
  output logic [5:0] led_segment_outputs_out,
  output logic led_common_out
);

  ggd_state_t state_r;
  ggd_state_t state_nxt;
  ggd_state_t reset_state;
  logic [7:0] filter_r;
  logic [7:0] rst_reg_r;
  logic [7:0] rst_reg_nxt;
  logic sw_reset_r;
  logic [7:0] rdata_r;
  logic rvalid_r;
  logic [7:0] rdata_nxt;
  logic [5:0] seg_r;
  logic [5:0] seg_nxt;
  logic common_r;
  logic [5:0] level;
  logic bank_odd;
  logic bank_even;
  logic blink_on;

  // Write strobe aimed at one register offset
  function automatic logic wr_hit(input ggd_reg_req_t r,
                                  input logic [7:0] a);
    wr_hit = r.wr && (r.addr == a);
  endfunction

  // Address decode
  wire wr_filter = wr_hit(reg_req_in, `GGD_ADDR_FILTER);
  wire wr_rst = wr_hit(reg_req_in, `GGD_ADDR_SW_RESET);
  wire wr_high = wr_hit(reg_req_in, `GGD_ADDR_CHARGE_HIGH);
  wire wr_learned = wr_hit(reg_req_in, `GGD_ADDR_LEARNED);

  // Soft reset fires only on a 00h to 80h change
  wire rst_trigger = wr_rst && rst_reg_r == `GGD_RST_IDLE &&
                     reg_req_in.wdata == `GGD_RST_TRIGGER;

  // Reset image of the gauge state
  always_comb
  begin
    reset_state = '0;
    reset_state.learned_capacity = programmed_full_capacity_in;
    reset_state.charge_count_high = program_input_six_in ?
      programmed_full_capacity_in : 8'h00;
    reset_state.capacity_inaccurate_flag = 1'b1;
    reset_state.pack_removed_flag = 1'b1;
  end

  // Next gauge state: soft reset, host write, then gauge core
  always_comb
  begin
    state_nxt = state_r;
    if (sw_reset_r)
      state_nxt = reset_state;
    else if (wr_high)
      state_nxt.charge_count_high = reg_req_in.wdata;
    else if (wr_learned)
      state_nxt.learned_capacity = reg_req_in.wdata;
    else if (gauge_update_in)
      state_nxt = gauge_state_in;
  end

  // Reset register holds its value until the reset has run
  always_comb
  begin
    rst_reg_nxt = rst_reg_r;
    if (sw_reset_r)
      rst_reg_nxt = `GGD_RST_IDLE;
    else if (wr_rst)
      rst_reg_nxt = reg_req_in.wdata;
  end

  // Read data mux, unmapped offsets read zero
  always_comb
  begin
    case (reg_req_in.addr)
      `GGD_ADDR_FILTER: rdata_nxt = filter_r;
      `GGD_ADDR_CHARGE_HIGH: rdata_nxt = state_r.charge_count_high;
      `GGD_ADDR_CHARGE_LOW: rdata_nxt = state_r.charge_count_low;
      `GGD_ADDR_LEARNED: rdata_nxt = state_r.learned_capacity;
      `GGD_ADDR_INACCURACY: rdata_nxt = state_r.inaccuracy_counter;
      default: rdata_nxt = 8'h00;
    endcase
  end

  // Power-on reset and register state
  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
    begin
      filter_r <= FILTER_RESET;
      rst_reg_r <= `GGD_RST_IDLE;
      sw_reset_r <= 1'b1;
      rdata_r <= 8'h00;
      rvalid_r <= 1'b0;
    end
    else
    begin
      if (wr_filter)
        filter_r <= reg_req_in.wdata;
      rst_reg_r <= rst_reg_nxt;
      sw_reset_r <= rst_trigger;
      rdata_r <= reg_req_in.rd ? rdata_nxt : rdata_r;
      rvalid_r <= reg_req_in.rd;
    end
  end

  // Gauge state; image loaded while reset is pending
  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
      state_r <= '0;
    else
      state_r <= state_nxt;
  end

  assign reg_rdata_out = rdata_r;
  assign reg_rvalid_out = rvalid_r;
  assign gauge_state_out = state_r;
  assign magnitude_filter_limits_out = filter_r;
  assign soft_reset_out = sw_reset_r;

  ggd_timebase #(
    .MUX_CYCLES(MUX_CYCLES),
    .BANK_CYCLES(BANK_CYCLES),
    .BLINK_CYCLES(BLINK_CYCLES)
  ) u_timebase (
    .sys_clk_in(sys_clk_in),
    .reset_in(reset_in),
    .bank_odd_out(bank_odd),
    .bank_even_out(bank_even),
    .blink_on_out(blink_on)
  );

  ggd_level u_level (
    .charge_high_in(state_r.charge_count_high),
    .learned_capacity_in(state_r.learned_capacity),
    .full_capacity_in(programmed_full_capacity_in),
    .temperature_in(temperature_gauge_reg_in),
    .absolute_mode_in(absolute_mode_in),
    .level_out(level)
  );

  // Display enable from pin level, activity and empty warnings
  wire display_enable_input_low = display_enable_input_in == GGD_DISPLAY_ENABLE_INPUT_LOW;
  wire display_enable_input_float = display_enable_input_in == GGD_DISPLAY_ENABLE_INPUT_FLOAT;
  wire counting = discharge_active_in || charge_active_in;
  wire display_enable_input_on = !final_empty_warning_in &&
                 (display_enable_input_low || (display_enable_input_float && counting));
  wire seg1_gate = !first_empty_warning_in || blink_on;

  // Odd segments on the odd bank, even segments on the even bank
  genvar s;
  generate
    for (s = 0; s < 6; s++)
    begin : g_out
      if (s % 2 == 0)
      begin : g_odd
        assign seg_nxt[s] = display_enable_input_on && level[s] && bank_odd &&
                            (s != 0 || seg1_gate);
      end
      else
      begin : g_even
        assign seg_nxt[s] = display_enable_input_on && level[s] && bank_even;
      end
    end
  endgenerate

  // Registered segment and common drive
  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
    begin
      seg_r <= 6'h00;
      common_r <= 1'b0;
    end
    else
    begin
      seg_r <= seg_nxt;
      common_r <= display_enable_input_on && (bank_odd || bank_even);
    end
  end

  assign led_segment_outputs_out = seg_r;
  assign led_common_out = common_r;

  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (reset_in);

  sequence s_trigger;
    rst_trigger;
  endsequence

  sequence s_reset_done;
    ##1 sw_reset_r ##1 (rst_reg_r == `GGD_RST_IDLE);
  endsequence

  filter_write_a: assert property (
    wr_filter |=> magnitude_filter_limits_out == $past(reg_req_in.wdata))
    else $error("filter register did not take the write");

  soft_reset_seq_a: assert property (
    s_trigger |=> soft_reset_out ##1
      (gauge_state_out.charge_count_low == 8'h00 &&
       gauge_state_out.inaccuracy_counter == 8'h00))
    else $error("soft reset did not clear the counts");

  reset_flags_a: assert property (
    soft_reset_out |=> gauge_state_out.capacity_inaccurate_flag &&
      gauge_state_out.pack_removed_flag &&
      gauge_state_out.learned_capacity ==
        $past(programmed_full_capacity_in))
    else $error("reset image not loaded");

  rst_clear_a: assert property (
    s_trigger |-> s_reset_done)
    else $error("reset register not returned to zero");

  relative_six_a: assert property (
    !absolute_mode_in |=> !led_segment_outputs_out[5])
    else $error("sixth segment lit in relative mode");

  display_enable_input_high_dark_a: assert property (
    display_enable_input_in == GGD_DISPLAY_ENABLE_INPUT_HIGH |=>
      led_segment_outputs_out == 6'h00)
    else $error("segments lit with display disabled");

  float_idle_a: assert property (
    display_enable_input_float && !counting |=> led_segment_outputs_out == 6'h00)
    else $error("segments lit without counting activity");

  low_shows_a: assert property (
    display_enable_input_low && !final_empty_warning_in && level[1] && bank_even
      |=> led_segment_outputs_out[1])
    else $error("segment two dark with display forced on");

  bank_split_a: assert property (
    !((|(led_segment_outputs_out & 6'h15)) &&
      (|(led_segment_outputs_out & 6'h2A))))
    else $error("both segment banks driven together");

  blink_off_a: assert property (
    first_empty_warning_in && !blink_on |=> !led_segment_outputs_out[0])
    else $error("segment one lit in blink off phase");

  final_dark_a: assert property (
    final_empty_warning_in |=> led_segment_outputs_out == 6'h00 &&
      !led_common_out)
    else $error("display active past final empty warning");

  fill_upward_a: assert property (
    (level[4:1] & ~level[3:0]) == 4'h0)
    else $error("segment bar has a gap below a lit segment");

  common_idle_a: assert property (
    !bank_odd && !bank_even |=> !led_common_out &&
      led_segment_outputs_out == 6'h00)
    else $error("display driven between bank phases");

  filter_read_a: assert property (
    reg_req_in.rd && reg_req_in.addr == `GGD_ADDR_FILTER |=>
      reg_rvalid_out && reg_rdata_out == $past(filter_r))
    else $error("filter read returned the wrong value");

  scale_keeps_a: assert property (
    $changed(temperature_gauge_reg_in) && !sw_reset_r && !wr_high &&
      !wr_learned && !gauge_update_in |=>
      $stable(gauge_state_out))
    else $error("temperature change altered the stored charge");

  sixth_dark_a: assert property (
    absolute_mode_in && !level[5] |=> !led_segment_outputs_out[5])
    else $error("overfull segment lit without overfull charge");

endmodule // ggd_display_top

// ---- logic/ggd_level.sv ----
// Bar graph level from charge, mode and temperature band.
// Assumes all inputs steady within a clock; purely combinational.
`timescale 1ns/10ps
`include "ggd_params.svh"
module ggd_level
  import ggd_pkg::*;
(
  input wire logic [7:0] charge_high_in,
  input wire logic [7:0] learned_capacity_in,
  input wire logic [7:0] full_capacity_in,
  input wire logic [3:0] temperature_in,
  input wire logic absolute_mode_in,
  output logic [5:0] level_out
);

  // Temperature scaled charge in quarters of a count
  function automatic logic [9:0] ggd_scale(input logic [7:0] c,
                                           input logic [3:0] t);
    logic [9:0] q;
    q = {c, 2'b00};
    if (t >= `GGD_TMP_BAND_ZERO)
      ggd_scale = q;
    else if (t >= `GGD_TMP_BAND_MINUS20)
      ggd_scale = q - {2'b00, c};
    else
      ggd_scale = {1'b0, c, 1'b0};
  endfunction

  wire [9:0] adj_q = ggd_scale(charge_high_in, temperature_in);
  wire [7:0] ref_cap = absolute_mode_in ? full_capacity_in
                                        : learned_capacity_in;
  wire [12:0] adj_x5 = 13'({adj_q, 2'b00}) + 13'(adj_q);
  wire [9:0] ref_q = {ref_cap, 2'b00};

  // Segment k lit when charge passes (k-1) fifths of the reference
  genvar k;
  generate
    for (k = 0; k < 5; k++)
    begin : g_seg
      assign level_out[k] = adj_x5 > 13'(ref_q * k);
    end
  endgenerate

  // Sixth segment shows overfull, absolute mode only
  assign level_out[5] = absolute_mode_in && (adj_q > ref_q);

endmodule // ggd_level

// ---- logic/ggd_params.svh ----
// Constants of the gauge display and soft reset block.
// Assumes one 200 MHz clock; included by its bare name.
`ifndef GGD_PARAMS_SVH
`define GGD_PARAMS_SVH

// Register offsets
`define GGD_ADDR_CHARGE_HIGH 8'h03
`define GGD_ADDR_LEARNED 8'h05
`define GGD_ADDR_INACCURACY 8'h09
`define GGD_ADDR_FILTER 8'h0A
`define GGD_ADDR_CHARGE_LOW 8'h17
`define GGD_ADDR_SW_RESET 8'h39

// Reset register values
`define GGD_RST_IDLE 8'h00
`define GGD_RST_TRIGGER 8'h80

// Filter register reset value
`define GGD_FILTER_RESET 8'h00

// Temperature band limits of the display scaling
`define GGD_TMP_BAND_ZERO 4'h4
`define GGD_TMP_BAND_MINUS20 4'h2

// Timing, in ns, and the clock period
`define GGD_CLK_NS 5
`define GGD_MUX_PERIOD_NS 10000000
`define GGD_BANK_ON_NS 3000000
`define GGD_BLINK_PERIOD_NS 250000000

`endif

// ---- logic/ggd_pkg.sv ----
// Types shared by the gauge display and soft reset block.
// Assumes ggd_params.svh holds the numeric constants.
package ggd_pkg;

  // Level of the three-state display enable pin
  typedef enum logic [1:0] {
    GGD_DISPLAY_ENABLE_INPUT_HIGH,
    GGD_DISPLAY_ENABLE_INPUT_FLOAT,
    GGD_DISPLAY_ENABLE_INPUT_LOW
  } ggd_display_enable_input_t;

  // Gauge state touched by a reset
  typedef struct packed {
    logic [7:0] learned_capacity;
    logic [7:0] charge_count_high;
    logic [7:0] charge_count_low;
    logic [7:0] inaccuracy_counter;
    logic discharge_valid_flag;
    logic capacity_inaccurate_flag;
    logic pack_removed_flag;
  } ggd_state_t;

  // Host register access
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ggd_reg_req_t;

endpackage

// ---- logic/ggd_timebase.sv ----
// Bank multiplex phases and the low battery blink clock.
// Assumes sys_clk_in at 200 MHz and a synchronous reset.
`timescale 1ns/10ps
`include "ggd_params.svh"
module ggd_timebase
  import ggd_pkg::*;
#(
  parameter int MUX_CYCLES = `GGD_MUX_PERIOD_NS / `GGD_CLK_NS,
  parameter int BANK_CYCLES = `GGD_BANK_ON_NS / `GGD_CLK_NS,
  parameter int BLINK_CYCLES = `GGD_BLINK_PERIOD_NS / `GGD_CLK_NS
)
(
  input wire logic sys_clk_in,
  input wire logic reset_in,
  output logic bank_odd_out,
  output logic bank_even_out,
  output logic blink_on_out
);

  localparam int MW = $clog2(MUX_CYCLES);
  localparam int BW = $clog2(BLINK_CYCLES);
  localparam logic [MW-1:0] MUX_LAST = MW'(MUX_CYCLES - 1);
  localparam logic [MW-1:0] HALF = MW'(MUX_CYCLES / 2);
  localparam logic [MW-1:0] BANK_ON = MW'(BANK_CYCLES);
  localparam logic [BW-1:0] BLINK_LAST = BW'(BLINK_CYCLES - 1);
  localparam logic [BW-1:0] BLINK_HALF = BW'(BLINK_CYCLES / 2);

  logic [MW-1:0] mux_cnt_r;
  logic [BW-1:0] blink_cnt_r;
  wire mux_wrap = (mux_cnt_r == MUX_LAST);
  wire blink_wrap = (blink_cnt_r == BLINK_LAST);

  // Free running period counters
  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
    begin
      mux_cnt_r <= '0;
      blink_cnt_r <= '0;
    end
    else
    begin
      mux_cnt_r <= mux_wrap ? '0 : mux_cnt_r + 1'b1;
      blink_cnt_r <= blink_wrap ? '0 : blink_cnt_r + 1'b1;
    end
  end

  // Odd bank first 30 percent, even bank from the half point
  assign bank_odd_out = (mux_cnt_r < BANK_ON);
  assign bank_even_out = (mux_cnt_r >= HALF) &&
                         (mux_cnt_r < HALF + BANK_ON);
  assign blink_on_out = (blink_cnt_r < BLINK_HALF);

endmodule // ggd_timebase

// ---- verification/ggd_led_panel.sv ----
// LED bar and display push-button seen from the far side.
// Assumes segments are only lit while the common driver is high.
`timescale 1ns/10ps
module ggd_led_panel
  import ggd_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic clear_in,
  input wire ggd_display_enable_input_t strap_in,
  input wire logic button_in,
  input wire logic [5:0] seg_in,
  input wire logic common_in,
  output ggd_display_enable_input_t display_enable_input_out,
  output logic [5:0] seen_out
);
  // Pressed button pulls the enable pin low, else the strap level
  assign display_enable_input_out = button_in ? GGD_DISPLAY_ENABLE_INPUT_LOW : strap_in;

  // Segments that glowed since the last clear
  always_ff @(posedge sys_clk_in)
  begin
    if (clear_in)
      seen_out <= 6'h00;
    else if (common_in === 1'b1)
      seen_out <= seen_out | seg_in;
  end
endmodule // ggd_led_panel

// ---- verification/tb_top.sv ----
// Self-checking bench of the gauge display and soft reset block.
// Assumes short multiplex counts and inputs driven 1 ns after edges.
`timescale 1ns/10ps
`include "ggd_params.svh"
module tb_top;
  import ggd_pkg::*;
  localparam int MUXC = 40;
  localparam int BANKC = 12;
  localparam int BLINKC = 64;
  logic sys_clk_in = 1'b0;
  logic reset_in = 1'b1;
  ggd_reg_req_t req = '0;
  logic [7:0] rdata, filt, rv, got, lc, ch;
  logic rvalid, srst, common, prog_six = 1'b0, abs_mode = 1'b0;
  logic upd = 1'b0;
  logic [7:0] full_cap = 8'hC8;
  logic [3:0] band = 4'h6;
  ggd_state_t st_in = '0;
  ggd_state_t st_out;
  logic dis_act = 1'b0, chg_act = 1'b0, button = 1'b0, clear = 1'b0;
  logic first_w = 1'b0, final_w = 1'b0;
  ggd_display_enable_input_t strap = GGD_DISPLAY_ENABLE_INPUT_FLOAT;
  ggd_display_enable_input_t display_enable_input;
  logic [5:0] segs, seen;
  int err_count = 0, comparisons = 0, n_srst = 0, ns;
  int n_odd, n_even, n_com, mix, s1_gap, s1_on;
  ggd_display_enable_input_t sm[5] = '{GGD_DISPLAY_ENABLE_INPUT_HIGH, GGD_DISPLAY_ENABLE_INPUT_FLOAT, GGD_DISPLAY_ENABLE_INPUT_FLOAT,
                       GGD_DISPLAY_ENABLE_INPUT_FLOAT, GGD_DISPLAY_ENABLE_INPUT_LOW};
  bit dm[5] = '{1, 0, 1, 0, 0};
  bit cm[5] = '{0, 0, 0, 1, 0};
  logic [5:0] em[5] = '{6'h00, 6'h00, 6'h3F, 6'h3F, 6'h3F};

  // Clock and reset pulse counter
  always #2.5 sys_clk_in = ~sys_clk_in;
  always @(posedge sys_clk_in) if (srst === 1'b1) n_srst++;

  ggd_display_top #(.MUX_CYCLES(MUXC), .BANK_CYCLES(BANKC),
    .BLINK_CYCLES(BLINKC)) DUT (
    .sys_clk_in(sys_clk_in), .reset_in(reset_in), .reg_req_in(req),
    .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
    .programmed_full_capacity_in(full_cap),
    .program_input_six_in(prog_six),
    .absolute_mode_in(abs_mode), .temperature_gauge_reg_in(band),
    .gauge_update_in(upd), .gauge_state_in(st_in),
    .discharge_active_in(dis_act), .charge_active_in(chg_act),
    .display_enable_input_in(display_enable_input), .first_empty_warning_in(first_w),
    .final_empty_warning_in(final_w), .gauge_state_out(st_out),
    .magnitude_filter_limits_out(filt), .soft_reset_out(srst),
    .led_segment_outputs_out(segs), .led_common_out(common));

  ggd_led_panel panel (.sys_clk_in(sys_clk_in), .clear_in(clear),
    .strap_in(strap), .button_in(button), .seg_in(segs),
    .common_in(common), .display_enable_input_out(display_enable_input), .seen_out(seen));

  // Comparison and closing tasks
  task automatic chk_byte(string nm, logic [7:0] e, logic [7:0] g);
    comparisons++;
    if (g !== e)
    begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_state(string nm, ggd_state_t e, ggd_state_t g);
    comparisons++;
    if (g !== e)
    begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_cnt(string nm, int e, int g);
    comparisons++;
    if (g != e)
    begin
      err_count++;
      $display("Error %s expected %0d seen %0d", nm, e, g);
    end
  endtask
  task automatic end_sim;
    $display("Checks %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Bus cycles, one cycle per strobe
  task automatic tick(int n);
    repeat (n) @(posedge sys_clk_in);
    #1;
  endtask
  task automatic reg_wr(logic [7:0] a, logic [7:0] d);
    req.wr = 1'b1;
    req.addr = a;
    req.wdata = d;
    tick(1);
    req.wr = 1'b0;
    tick(1);
  endtask
  task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
    req.rd = 1'b1;
    req.addr = a;
    tick(1);
    req.rd = 1'b0;
    chk_byte("read valid", 8'h01, {7'h00, rvalid});
    d = rdata;
    tick(1);
  endtask

  // Watch the bar for n cycles, counting bank activity
  task automatic watch(int n);
    tick(1);
    clear = 1'b1;
    tick(1);
    clear = 1'b0;
    {n_odd, n_even, n_com, mix, s1_gap, s1_on} = '0;
    repeat (n)
    begin
      tick(1);
      if (|(segs & 6'h15)) n_odd++;
      if (|(segs & 6'h2A)) n_even++;
      if (common === 1'b1) n_com++;
      if (|(segs & 6'h15) && |(segs & 6'h2A)) mix++;
      if (segs[2] === 1'b1 && segs[0] === 1'b0) s1_gap++;
      if (segs[0] === 1'b1) s1_on++;
    end
  endtask

  // Reference model of the bar level and reset image
  function automatic logic [5:0] exp_level(int c, int l, int f, int b,
                                           bit am);
    int adj, rf;
    logic [5:0] v;
    adj = b >= 4 ? c : (b >= 2 ? c * 3 / 4 : c / 2);
    rf = am ? f : l;
    v = '0;
    for (int k = 1; k <= 5; k++) v[k-1] = (5 * adj > (k - 1) * rf);
    v[5] = am && adj > rf;
    return v;
  endfunction
  function automatic ggd_state_t img(logic [7:0] f, logic p6);
    ggd_state_t s;
    s = '0;
    s.learned_capacity = f;
    s.charge_count_high = p6 ? f : 8'h00;
    s.capacity_inaccurate_flag = 1'b1;
    s.pack_removed_flag = 1'b1;
    return s;
  endfunction

  // Hang guard
  initial
  begin
    #(5 * 20000);
    err_count++;
    $display("Error watchdog expected done seen hang");
    end_sim();
  end

  // Main sequence
  initial
  begin
    void'($urandom(30152));
    tick(3);
    reset_in = 1'b0;
    tick(3);
    chk_state("power on image", img(full_cap, 1'b0), st_out);
    reg_rd(`GGD_ADDR_FILTER, got);
    chk_byte("filter reset", `GGD_FILTER_RESET, got);
    repeat (4)
    begin
      rv = 8'(8'h08 + $urandom % 248);
      reg_wr(`GGD_ADDR_FILTER, rv);
      reg_rd(`GGD_ADDR_FILTER, got);
      chk_byte("filter read", rv, got);
      chk_byte("filter out", rv, filt);
    end
    reg_wr(`GGD_ADDR_INACCURACY, 8'hFF);
    reg_rd(`GGD_ADDR_INACCURACY, got);
    chk_byte("read only", 8'h00, got);
    reg_rd(8'h3F, got);
    chk_byte("unmapped", 8'h00, got);
    for (int p = 0; p < 2; p++)
    begin
      prog_six = p[0];
      full_cap = 8'h10 | 8'($urandom);
      st_in = 35'({$urandom, $urandom});
      upd = 1'b1;
      tick(1);
      upd = 1'b0;
      tick(1);
      chk_state("update", st_in, st_out);
      ns = n_srst;
      reg_wr(`GGD_ADDR_SW_RESET, `GGD_RST_TRIGGER);
      tick(2);
      chk_state("soft reset", img(full_cap, prog_six), st_out);
      chk_cnt("reset pulses", 1, n_srst - ns);
      reg_rd(`GGD_ADDR_SW_RESET, got);
      chk_byte("reset reg", `GGD_RST_IDLE, got);
      chk_byte("filter kept", rv, filt);
    end
    button = 1'b1;
    for (int i = 0; i < 26; i++)
    begin
      band = 4'(i % 13);
      abs_mode = (i >= 13);
      full_cap = 8'(8'h40 + $urandom % 192);
      lc = 8'(8'h01 + $urandom % 255);
      ch = 8'(($urandom % 64) * 4);
      reg_wr(`GGD_ADDR_LEARNED, lc);
      reg_wr(`GGD_ADDR_CHARGE_HIGH, ch);
      watch(MUXC);
      got = {2'b00, exp_level(ch, lc, full_cap, band, abs_mode)};
      chk_byte("segments", got, seen);
      chk_cnt("bank overlap", 0, mix);
    end
    full_cap = 8'h80;
    band = 4'h6;
    reg_wr(`GGD_ADDR_CHARGE_HIGH, 8'hFC);
    watch(MUXC);
    chk_cnt("odd bank cycles", BANKC, n_odd);
    chk_cnt("even bank cycles", BANKC, n_even);
    chk_cnt("common cycles", 2 * BANKC, n_com);
    button = 1'b0;
    for (int m = 0; m < 5; m++)
    begin
      strap = sm[m];
      dis_act = dm[m];
      chg_act = cm[m];
      watch(MUXC);
      chk_byte("enable mode", em[m], seen);
    end
    first_w = 1'b1;
    watch(2 * BLINKC);
    chk_cnt("blink dark", 1, int'(s1_gap > 0));
    chk_cnt("blink lit", 1, int'(s1_on > 0));
    first_w = 1'b0;
    final_w = 1'b1;
    watch(MUXC);
    chk_byte("final blank", 8'h00, seen);
    end_sim();
  end
endmodule // tb_top
